/* File: design/slis_map.vh */
// Summary of operation
// - latch all straps when reset releases
// - shared pins take exactly one mode
// - both straps pulled up selects smbus slave
// - data strap pulled down selects uart
// - no pulls selects serial flash first
// - no valid rom falls to i2c bridging
// - never enable conflicting interface pairs together
// - rom valid only with signature present
// - smbus/i2c usable only in configs 1,2,3,6
// - uart uses data pin tx, clock rx
`ifndef SLIS_MAP_VH
`define SLIS_MAP_VH

// strap detector classification of one shared pin
`define SLIS_STRAP_NONE 2'h0
`define SLIS_STRAP_PU10K 2'h1
`define SLIS_STRAP_PD10K 2'h2

// shared pin group function codes
`define SLIS_MODE_SPI 2'h0
`define SLIS_MODE_SMB 2'h1
`define SLIS_MODE_I2C 2'h2
`define SLIS_MODE_UART 2'h3

// device mode strap configurations that route smbus data/clock
`define SLIS_DEVCFG_1 3'h1
`define SLIS_DEVCFG_2 3'h2
`define SLIS_DEVCFG_3 3'h3
`define SLIS_DEVCFG_6 3'h6

// serial rom signature probe
`define SLIS_ROM_READ_CMD 8'h03
`define SLIS_ROM_SIG_ADDR 24'h00FFFA
`define SLIS_ROM_SIG 32'h32444655
`define SLIS_ROM_HDR_BITS 7'h20
`define SLIS_ROM_LAST_BIT 7'h3F

// rom clock timing
`define SLIS_CLK_PERIOD_NS 8
`define SLIS_SCK_HALF_NS 40

`endif

/* File: design/slis_rom_probe.v */
`timescale 1ns/1ps
`include "slis_map.vh"

// reads four bytes at the signature address, spi mode 0, msb first
module slis_rom_probe #(
   parameter HALF_CYC = (`SLIS_SCK_HALF_NS + `SLIS_CLK_PERIOD_NS - 1) / `SLIS_CLK_PERIOD_NS
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire start,
   input wire miso,
   output reg sck,
   output reg cs_n,
   output reg mosi,
   output reg done,
   output reg sig_ok
);
   // named copy of the read command so its top bit can be picked without a shift
   localparam [7:0] READ_CMD = `SLIS_ROM_READ_CMD;
   reg busy;
   reg [7:0] half_cnt;
   reg [6:0] bit_cnt;
   reg [31:0] tx_shift;
   reg [31:0] rx_shift;
   wire half_tick;

   assign half_tick = (half_cnt == HALF_CYC[7:0] - 8'h01);

   // one frame: 8 command bits, 24 address bits, 32 data bits
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy <= 1'b0;
         half_cnt <= 8'h00;
         bit_cnt <= 7'h00;
         tx_shift <= 32'h00000000;
         rx_shift <= 32'h00000000;
         sck <= 1'b0;
         cs_n <= 1'b1;
         mosi <= 1'b0;
         done <= 1'b0;
         sig_ok <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            cs_n <= 1'b0;
            half_cnt <= 8'h00;
            bit_cnt <= 7'h00;
            tx_shift <= {`SLIS_ROM_READ_CMD, `SLIS_ROM_SIG_ADDR};
            mosi <= READ_CMD[7];
         end else if (busy) begin
            half_cnt <= half_tick ? 8'h00 : half_cnt + 8'h01;
            if (half_tick && !sck) begin
               // rising edge: the rom data is sampled here
               sck <= 1'b1;
               if (bit_cnt >= `SLIS_ROM_HDR_BITS)
                  rx_shift <= {rx_shift[30:0], miso};
            end else if (half_tick) begin
               sck <= 1'b0;
               if (bit_cnt == `SLIS_ROM_LAST_BIT) begin
                  busy <= 1'b0;
                  cs_n <= 1'b1;
                  done <= 1'b1;
                  sig_ok <= (rx_shift == `SLIS_ROM_SIG);
               end else begin
                  bit_cnt <= bit_cnt + 7'h01;
                  tx_shift <= {tx_shift[30:0], 1'b0};
                  mosi <= tx_shift[30];
               end
            end
         end
      end
   end
endmodule

/* File: design/slis_top.v */
`timescale 1ns/1ps
`include "slis_map.vh"

// strap latch and shared serial pin function select
module slis_top #(
   parameter SCK_HALF_CYC = (`SLIS_SCK_HALF_NS + `SLIS_CLK_PERIOD_NS - 1) / `SLIS_CLK_PERIOD_NS
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire ext_rst_n,
   input wire [1:0] sdo_strap_class,
   input wire [1:0] sclk_strap_class,
   input wire [2:0] dev_cfg_strap,
   input wire sdo_pin_in,
   output reg sdo_pin_out,
   output reg sdo_pin_oe,
   input wire sclk_pin_in,
   output reg sclk_pin_out,
   output reg sclk_pin_oe,
   input wire sdi_pin_in,
   output reg cs_n_pin_out,
   output reg cs_n_pin_oe,
   input wire uart_tx_data,
   output reg uart_rx_data,
   output reg [1:0] serial_interface_select_strap,
   output reg [2:0] dev_cfg_latched,
   output reg mode_valid,
   output reg spi_en,
   output reg smbus_slave_en,
   output reg i2c_bridge_en,
   output reg uart_en,
   output reg smbus_pins_routed
);
   localparam ST_WAIT = 3'h0;
   localparam ST_DECIDE = 3'h1;
   localparam ST_PROBE = 3'h2;
   localparam ST_PROBE_WAIT = 3'h3;
   localparam ST_DONE = 3'h4;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [1:0] sdo_class_q;
   reg [1:0] sclk_class_q;
   reg [1:0] mode;
   reg [1:0] next_mode;
   reg probe_start;
   reg next_probe_start;
   wire probe_sck;
   wire probe_cs_n;
   wire probe_mosi;
   wire probe_done;
   wire probe_ok;
   wire probing;

   // strap class pair to pin group function
   function [1:0] slis_pick_mode;
      input [1:0] sdo_class;
      input [1:0] sclk_class;
      begin
         if (sdo_class == `SLIS_STRAP_PU10K && sclk_class == `SLIS_STRAP_PU10K)
            slis_pick_mode = `SLIS_MODE_SMB;
         else if (sdo_class == `SLIS_STRAP_PD10K)
            slis_pick_mode = `SLIS_MODE_UART;
         else
            slis_pick_mode = `SLIS_MODE_SPI;
      end
   endfunction

   // device configurations that carry smbus data and clock
   function slis_smb_routed;
      input [2:0] cfg;
      begin
         slis_smb_routed = (cfg == `SLIS_DEVCFG_1) || (cfg == `SLIS_DEVCFG_2) ||
                           (cfg == `SLIS_DEVCFG_3) || (cfg == `SLIS_DEVCFG_6);
      end
   endfunction

   // the probe owns the shared pins only while it runs
   assign probing = (state == ST_PROBE) || (state == ST_PROBE_WAIT);

   slis_rom_probe #(
      .HALF_CYC(SCK_HALF_CYC)
   ) u_probe (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .start(probe_start),
      .miso(sdi_pin_in),
      .sck(probe_sck),
      .cs_n(probe_cs_n),
      .mosi(probe_mosi),
      .done(probe_done),
      .sig_ok(probe_ok)
   );

   // straps are caught on the first edge after both resets are gone;
   // the external reset is a synchronous input, so it can only restart the
   // sequence here and cannot take a value under the asynchronous reset
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sdo_class_q <= `SLIS_STRAP_NONE;
         sclk_class_q <= `SLIS_STRAP_NONE;
         dev_cfg_latched <= 3'h0;
      end else if (!ext_rst_n) begin
         sdo_class_q <= `SLIS_STRAP_NONE;
         sclk_class_q <= `SLIS_STRAP_NONE;
         dev_cfg_latched <= 3'h0;
      end else if (state == ST_WAIT) begin
         sdo_class_q <= sdo_strap_class;
         sclk_class_q <= sclk_strap_class;
         dev_cfg_latched <= dev_cfg_strap;
      end
   end

   // selection sequence; the done state is left only through a reset
   always @* begin
      next_state = state;
      next_mode = mode;
      next_probe_start = 1'b0;
      case (state)
         ST_WAIT: begin
            next_state = ST_DECIDE;
         end
         ST_DECIDE: begin
            next_mode = slis_pick_mode(sdo_class_q, sclk_class_q);
            if (slis_pick_mode(sdo_class_q, sclk_class_q) == `SLIS_MODE_SPI)
               next_state = ST_PROBE;
            else
               next_state = ST_DONE;
         end
         ST_PROBE: begin
            next_probe_start = 1'b1;
            next_state = ST_PROBE_WAIT;
         end
         ST_PROBE_WAIT: begin
            if (probe_done) begin
               if (!probe_ok)
                  next_mode = `SLIS_MODE_I2C;
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            next_state = ST_DONE;
         end
         default: begin
            next_state = ST_WAIT;
         end
      endcase
   end

   // state registers; external reset restarts the whole selection
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_WAIT;
         mode <= `SLIS_MODE_SPI;
         probe_start <= 1'b0;
      end else if (!ext_rst_n) begin
         state <= ST_WAIT;
         mode <= `SLIS_MODE_SPI;
         probe_start <= 1'b0;
      end else begin
         state <= next_state;
         mode <= next_mode;
         probe_start <= next_probe_start;
      end
   end

   // status and enables, at most one set, only once the choice is final;
   // one-hot decode keeps uart, smbus, spi and i2c mutually exclusive
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         serial_interface_select_strap <= `SLIS_MODE_SPI;
         mode_valid <= 1'b0;
         spi_en <= 1'b0;
         smbus_slave_en <= 1'b0;
         i2c_bridge_en <= 1'b0;
         uart_en <= 1'b0;
         smbus_pins_routed <= 1'b0;
      end else if (!ext_rst_n || state != ST_DONE) begin
         serial_interface_select_strap <= `SLIS_MODE_SPI;
         mode_valid <= 1'b0;
         spi_en <= 1'b0;
         smbus_slave_en <= 1'b0;
         i2c_bridge_en <= 1'b0;
         uart_en <= 1'b0;
         smbus_pins_routed <= 1'b0;
      end else begin
         serial_interface_select_strap <= mode;
         mode_valid <= 1'b1;
         smbus_pins_routed <= slis_smb_routed(dev_cfg_latched);
         spi_en <= (mode == `SLIS_MODE_SPI);
         uart_en <= (mode == `SLIS_MODE_UART);
         smbus_slave_en <= (mode == `SLIS_MODE_SMB) && slis_smb_routed(dev_cfg_latched);
         i2c_bridge_en <= (mode == `SLIS_MODE_I2C) && slis_smb_routed(dev_cfg_latched);
      end
   end

   // pin drive: undriven until the choice is made so the board pulls stay readable
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sdo_pin_out <= 1'b0;
         sdo_pin_oe <= 1'b0;
         sclk_pin_out <= 1'b0;
         sclk_pin_oe <= 1'b0;
         cs_n_pin_out <= 1'b1;
         cs_n_pin_oe <= 1'b0;
         uart_rx_data <= 1'b1;
      end else if (!ext_rst_n) begin
         sdo_pin_out <= 1'b0;
         sdo_pin_oe <= 1'b0;
         sclk_pin_out <= 1'b0;
         sclk_pin_oe <= 1'b0;
         cs_n_pin_out <= 1'b1;
         cs_n_pin_oe <= 1'b0;
         uart_rx_data <= 1'b1;
      end else if (probing) begin
         sdo_pin_out <= probe_mosi;
         sdo_pin_oe <= 1'b1;
         sclk_pin_out <= probe_sck;
         sclk_pin_oe <= 1'b1;
         cs_n_pin_out <= probe_cs_n;
         cs_n_pin_oe <= 1'b1;
         uart_rx_data <= 1'b1;
      end else if (state == ST_DONE && mode == `SLIS_MODE_UART) begin
         sdo_pin_out <= uart_tx_data;
         sdo_pin_oe <= 1'b1;
         sclk_pin_out <= 1'b0;
         sclk_pin_oe <= 1'b0;
         cs_n_pin_out <= 1'b1;
         cs_n_pin_oe <= 1'b0;
         uart_rx_data <= sclk_pin_in;
      end else if (state == ST_DONE && mode == `SLIS_MODE_SPI) begin
         // valid rom: bus idles with chip select held high
         sdo_pin_out <= 1'b0;
         sdo_pin_oe <= 1'b1;
         sclk_pin_out <= 1'b0;
         sclk_pin_oe <= 1'b1;
         cs_n_pin_out <= 1'b1;
         cs_n_pin_oe <= 1'b1;
         uart_rx_data <= 1'b1;
      end else begin
         // smbus and i2c use other pins; these stay as strap inputs
         sdo_pin_out <= 1'b0;
         sdo_pin_oe <= 1'b0;
         sclk_pin_out <= 1'b0;
         sclk_pin_oe <= 1'b0;
         cs_n_pin_out <= 1'b1;
         cs_n_pin_oe <= 1'b0;
         uart_rx_data <= 1'b1;
      end
   end
endmodule

/* File: verif/slis_props.sv */
`timescale 1ns/1ps
`include "slis_map.vh"

// watches the strap latch outputs; all checks except chk_reset_idle are off while either reset holds
module slis_props (
   input wire ref_clk,
   input wire sys_rst,
   input wire ext_rst_n,
   input wire sclk_pin_in,
   input wire uart_tx_data,
   input wire sdo_pin_out,
   input wire sdo_pin_oe,
   input wire sclk_pin_oe,
   input wire cs_n_pin_out,
   input wire cs_n_pin_oe,
   input wire uart_rx_data,
   input wire [1:0] serial_interface_select_strap,
   input wire [2:0] dev_cfg_latched,
   input wire mode_valid,
   input wire spi_en,
   input wire smbus_slave_en,
   input wire i2c_bridge_en,
   input wire uart_en,
   input wire smbus_pins_routed
);
   wire [1:0] sel = serial_interface_select_strap;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst || !ext_rst_n);
   // the reset check must run during reset, so it drops the default disable
   chk_reset_idle: assert property (disable iff (1'b0) sys_rst |-> !mode_valid && !spi_en && !uart_en
      && !sdo_pin_oe && !sclk_pin_oe && !cs_n_pin_oe && cs_n_pin_out) else $error("outputs not idle in reset");
   chk_one_iface: assert property ($onehot0({spi_en, smbus_slave_en, i2c_bridge_en, uart_en}))
      else $error("two interfaces enabled");
   chk_hold_sel: assert property (mode_valid |=> mode_valid && $stable(sel) && $stable(dev_cfg_latched))
      else $error("latched selection moved");
   chk_cfg_routed: assert property (mode_valid |-> smbus_pins_routed == (dev_cfg_latched inside {`SLIS_DEVCFG_1,
      `SLIS_DEVCFG_2, `SLIS_DEVCFG_3, `SLIS_DEVCFG_6})) else $error("routing flag wrong");
   chk_smb_route: assert property (smbus_slave_en || i2c_bridge_en |-> smbus_pins_routed)
      else $error("smbus used without routing");
   chk_smb_mode: assert property (mode_valid && sel == `SLIS_MODE_SMB |-> smbus_slave_en == smbus_pins_routed)
      else $error("smbus enable wrong");
   chk_uart_mode: assert property (mode_valid && sel == `SLIS_MODE_UART |-> uart_en)
      else $error("uart enable missing");
   chk_spi_mode: assert property (mode_valid && sel == `SLIS_MODE_SPI |-> spi_en && cs_n_pin_out && cs_n_pin_oe)
      else $error("flash mode wrong");
   chk_i2c_mode: assert property (mode_valid && sel == `SLIS_MODE_I2C |-> i2c_bridge_en == smbus_pins_routed)
      else $error("bridge enable wrong");
   chk_uart_tx: assert property (uart_en && $past(uart_en) |-> sdo_pin_oe && sdo_pin_out == $past(uart_tx_data))
      else $error("uart tx path wrong");
   chk_uart_rx: assert property (uart_en && $past(uart_en) |-> !sclk_pin_oe && uart_rx_data == $past(sclk_pin_in))
      else $error("uart rx path wrong");
endmodule

/* File: verif/slis_rom_model.sv */
`timescale 1ns/1ps

// serial rom, mode 0: header in on rising sck, reply out on falling sck
module slis_rom_model #(
   parameter [31:0] SIG = 32'h32444655
) (
   input wire sck,
   input wire cs_n,
   input wire mosi,
   input wire good,
   output reg miso
);
   reg [31:0] hdr = 32'h0;
   integer cnt = 0;
   initial miso = 1'b0;
   // command and address collected, frozen after 32 bits
   always @(posedge sck) if (!cs_n) begin
      if (cnt < 32) hdr <= {hdr[30:0], mosi};
      cnt <= cnt + 1;
   end
   // a blank part or a wrong header reads back inverted signature
   always @(negedge sck) if (!cs_n && cnt >= 32 && cnt < 64) begin
      miso <= (good && hdr == 32'h0300FFFA) ? SIG[63 - cnt] : ~SIG[63 - cnt];
   end
   // deselection drives the inverse of the last bit, so the line never repeats it
   always @(posedge cs_n) begin
      cnt <= 0;
      miso <= ~miso;
   end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps

module testbench;
   reg ref_clk = 1'b0;
   reg sys_rst = 1'b0;
   reg ext_rst_n = 1'b1;
   reg [1:0] sdo_cls = 2'h0;
   reg [1:0] sclk_cls = 2'h0;
   reg [2:0] cfg = 3'h1;
   reg tx = 1'b0;
   reg line = 1'b1;
   reg good = 1'b1;
   wire sdo_out, sdo_oe, sclk_out, sclk_oe, cs_n, miso, rx, valid;
   wire en_spi, en_smb, en_i2c, en_uart, routed;
   wire [1:0] sel;
   wire [2:0] cfg_l;
   integer seed = 32'h4a27c151;
   integer miscompares = 0;
   integer compares = 0;
   integer t, n;
   reg [9:0] exp_q[$];
   reg [9:0] e;
   reg [1:0] m;
   reg r;
   initial forever #4 ref_clk = ~ref_clk;
   // pads resolve to the device drive, else to a wandering board level;
   // half period of 2: the rom pins lag the probe by a register, so 1 would leave no setup on miso
   slis_top #(.SCK_HALF_CYC(2)) slis_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .ext_rst_n(ext_rst_n),
      .sdo_strap_class(sdo_cls), .sclk_strap_class(sclk_cls), .dev_cfg_strap(cfg),
      .sdo_pin_in(sdo_oe ? sdo_out : line), .sdo_pin_out(sdo_out), .sdo_pin_oe(sdo_oe),
      .sclk_pin_in(sclk_oe ? sclk_out : line), .sclk_pin_out(sclk_out), .sclk_pin_oe(sclk_oe),
      .sdi_pin_in(miso), .cs_n_pin_out(cs_n), .cs_n_pin_oe(), .uart_tx_data(tx), .uart_rx_data(rx),
      .serial_interface_select_strap(sel), .dev_cfg_latched(cfg_l), .mode_valid(valid), .spi_en(en_spi),
      .smbus_slave_en(en_smb), .i2c_bridge_en(en_i2c), .uart_en(en_uart), .smbus_pins_routed(routed));
   slis_rom_model slis_rom_model_i (.sck(sclk_out), .cs_n(cs_n), .mosi(sdo_out), .good(good), .miso(miso));
   task check(input [9:0] seen, input [9:0] want);
      begin
         compares = compares + 1;
         if (seen !== want) begin
            miscompares = miscompares + 1;
            $display("[ERR] mode_word expected %h seen %h", want, seen);
         end
      end
   endtask
   task give_verdict;
      begin
         if (miscompares == 0 && compares > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   // uart traffic and the idle pad level are redrawn at random every cycle
   always @(posedge ref_clk) begin
      tx <= 1'($random(seed));
      line <= 1'($random(seed));
   end
   // result check when the selection becomes final
   always @(posedge valid) begin
      #1;
      if (exp_q.size() > 0) check({sel, cfg_l, routed, en_spi, en_smb, en_i2c, en_uart}, exp_q.pop_front());
   end
   initial begin
      #240000;
      miscompares = miscompares + 1;
      give_verdict;
   end
   initial begin
      // raised by a nonblocking write so the asynchronous reset sees a real edge at time zero
      sys_rst <= 1'b1;
      repeat (20) @(posedge ref_clk);
      for (t = 0; t < 60; t = t + 1) begin
         @(posedge ref_clk);
         // alternate power-on and external reset; straps settle before release
         if (t[0]) sys_rst <= 1'b1;
         else ext_rst_n <= 1'b0;
         sdo_cls <= 2'($unsigned($random(seed)) % 3);
         sclk_cls <= 2'($unsigned($random(seed)) % 3);
         cfg <= 3'h1 + 3'($unsigned($random(seed)) % 6);
         good <= 1'($random(seed));
         repeat (2) @(posedge ref_clk);
         sys_rst <= 1'b0;
         ext_rst_n <= 1'b1;
         r = (cfg == 3'h1) || (cfg == 3'h2) || (cfg == 3'h3) || (cfg == 3'h6);
         if (sdo_cls == 2'h1 && sclk_cls == 2'h1) m = 2'h1;
         else if (sdo_cls == 2'h2) m = 2'h3;
         else m = good ? 2'h0 : 2'h2;
         e = {m, cfg, r, m == 2'h0, m == 2'h1 && r, m == 2'h2 && r, m == 2'h3};
         exp_q.push_back(e);
         repeat (2) @(posedge ref_clk);
         // later strap moves must be ignored
         sdo_cls <= 2'($unsigned($random(seed)) % 3);
         sclk_cls <= 2'($unsigned($random(seed)) % 3);
         cfg <= 3'h1 + 3'($unsigned($random(seed)) % 6);
         n = 0;
         while (valid !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n = n + 1;
         end
         if (n == 400) miscompares = miscompares + 1;
         repeat (12) @(posedge ref_clk);
      end
      give_verdict;
   end
endmodule

bind slis_top slis_props slis_props_i (.*);
